// *** hw/dsas_pkg.sv ***
// How it works
// - oscillator select picks RC or crystal
// - crystal mode divides oscillator by fifteen
// - nominal cycle 400 ms, integrate 100 ms
// - phases: zero, integrate, deintegrate, integrator zero
// - system zero grounds buffer, closes loop
// - signal integrate lasts 16384 ticks
// - counter runs until comparator zero crossing
// - crossing loads latches, drops valid flag
// - deintegrate bounded at 32678 ticks
// - integrator zero lasts 4096 ticks
// - run/hold low holds system zero
// - conversion starts only with run/hold high
// - valid flag high ignores run/hold
// - run/hold low after crossing ends deintegrate
// - result is sign plus fifteen magnitude bits
// - sign valid below one LSB
// - sixteen latched outputs with three-state release
// - two controls plus three dual-purpose strobes
package dsas_pkg;

    ////////////////////////////////////////////////////////////////////////
    localparam int unsigned SYS_CLK_MHZ     = 250;
    localparam logic [3:0]  PRESCALE_XTAL   = 4'hF;
    localparam logic [3:0]  PRESCALE_RC     = 4'h1;
    localparam int unsigned NOMINAL_TICK_HZ = 163840;
    localparam int unsigned CYCLE_MS        = 400;
    localparam int unsigned SIG_MS          = 100;
    localparam int unsigned CYCLE_TICKS     = CYCLE_MS * NOMINAL_TICK_HZ / 1000;
    localparam int unsigned SIG_TICKS       = SIG_MS * NOMINAL_TICK_HZ / 1000;
    localparam int unsigned REF_TICKS       = 32678;
    localparam int unsigned INT_TICKS       = 4096;
    localparam int unsigned SYS_TICKS       = CYCLE_TICKS - SIG_TICKS - REF_TICKS - INT_TICKS;
    localparam int unsigned MAG_MAX_TICKS   = 32768;

    ////////////////////////////////////////////////////////////////////////
    localparam logic [7:0]  ADDR_CTRL   = 8'h00;
    localparam logic [7:0]  ADDR_STATUS = 8'h04;
    localparam logic [7:0]  ADDR_RESULT = 8'h08;
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic strobe_mode;
        logic data_oe;
        logic run_hold;
        logic osc_crystal;
    } dsas_ctrl_t;

    localparam logic [3:0] CTRL_RESET = 4'h1;

    typedef enum logic [1:0] {
        PH_SYS_ZERO,
        PH_SIG_INT,
        PH_REF_INT,
        PH_INT_ZERO
    } dsas_phase_t;

    typedef struct packed {
        logic buf_to_common;
        logic loop_closed;
        logic input_to_int;
        logic ref_to_int;
        logic comp_to_buf;
    } dsas_switch_t;

endpackage

// *** hw/dsas_sequencer.sv ***
`timescale 1ns/100ps
module dsas_sequencer #(
    parameter int unsigned SIG_TICKS = dsas_pkg::SIG_TICKS,
    parameter int unsigned REF_TICKS = dsas_pkg::REF_TICKS,
    parameter int unsigned SYS_TICKS = dsas_pkg::SYS_TICKS
) (
    // clock and reset
    input  wire logic                  sys_clk,
    input  wire logic                  rst,
    // axi4-lite slave
    input  wire logic [7:0]            s_axi_awaddr,
    input  wire logic                  s_axi_awvalid,
    output logic                       s_axi_awready,
    input  wire logic [31:0]           s_axi_wdata,
    input  wire logic [3:0]            s_axi_wstrb,
    input  wire logic                  s_axi_wvalid,
    output logic                       s_axi_wready,
    output logic [1:0]                 s_axi_bresp,
    output logic                       s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    input  wire logic [7:0]            s_axi_araddr,
    input  wire logic                  s_axi_arvalid,
    output logic                       s_axi_arready,
    output logic [31:0]                s_axi_rdata,
    output logic [1:0]                 s_axi_rresp,
    output logic                       s_axi_rvalid,
    input  wire logic                  s_axi_rready,
    // comparator from analog front end
    input  wire logic                  comp_zero,
    input  wire logic                  comp_polarity,
    // analog switch controls
    output dsas_pkg::dsas_switch_t     switches,
    // output latches and strobe pins
    output logic [15:0]                data_o,
    output logic                       data_oe,
    input  wire logic [2:0]            strobe_i,
    output logic [2:0]                 strobe_o,
    output logic [2:0]                 strobe_oe,
    output logic                       result_valid_flag
);

    if (REF_TICKS > dsas_pkg::MAG_MAX_TICKS || REF_TICKS < 2 || SIG_TICKS < 2
        || SIG_TICKS > 65536 || SYS_TICKS < 2 || SYS_TICKS > 65536)
    begin : g_bad_params
        $error("dsas_sequencer: phase lengths out of range");
    end

    ////////////////////////////////////////////////////////////////////////
    // register file
    dsas_pkg::dsas_ctrl_t ctrl;
    dsas_pkg::dsas_ctrl_t next_ctrl;
    logic                 aw_held;
    logic [7:0]           aw_addr_q;
    logic                 w_held;
    logic [31:0]          w_data_q;
    logic [3:0]           w_strb_q;

    wire        aw_take   = s_axi_awvalid && s_axi_awready;
    wire        w_take    = s_axi_wvalid && s_axi_wready;
    wire        have_aw   = aw_held || aw_take;
    wire        have_w    = w_held || w_take;
    wire        do_write  = have_aw && have_w && !s_axi_bvalid;
    wire [7:0]  wr_addr   = aw_held ? aw_addr_q : s_axi_awaddr;
    wire [31:0] wr_data   = w_held ? w_data_q : s_axi_wdata;
    wire [3:0]  wr_strb   = w_held ? w_strb_q : s_axi_wstrb;
    wire        wr_ctrl   = do_write && wr_addr == dsas_pkg::ADDR_CTRL;
    wire        wr_mapped = wr_ctrl || wr_addr == dsas_pkg::ADDR_STATUS
                            || wr_addr == dsas_pkg::ADDR_RESULT;

    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready  = !w_held && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;

    // status and result are read-only; writes to them are acknowledged and dropped
    assign next_ctrl = (wr_ctrl && wr_strb[0]) ? dsas_pkg::dsas_ctrl_t'(wr_data[3:0]) : ctrl;

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            aw_held      <= 1'b0;
            aw_addr_q    <= 8'h00;
            w_held       <= 1'b0;
            w_data_q     <= 32'h00000000;
            w_strb_q     <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= dsas_pkg::RESP_OKAY;
            ctrl         <= dsas_pkg::dsas_ctrl_t'(dsas_pkg::CTRL_RESET);
        end
        else
        begin
            ctrl <= next_ctrl;
            if (do_write)
            begin
                aw_held      <= 1'b0;
                w_held       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_mapped ? dsas_pkg::RESP_OKAY : dsas_pkg::RESP_SLVERR;
            end
            else
            begin
                if (aw_take)
                begin
                    aw_held   <= 1'b1;
                    aw_addr_q <= s_axi_awaddr;
                end
                if (w_take)
                begin
                    w_held   <= 1'b1;
                    w_data_q <= s_axi_wdata;
                    w_strb_q <= s_axi_wstrb;
                end
                if (s_axi_bvalid && s_axi_bready)
                    s_axi_bvalid <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // prescaler and phase sequencer
    dsas_pkg::dsas_phase_t phase;
    dsas_pkg::dsas_phase_t next_phase;
    logic [3:0]            pre;
    logic [15:0]           phase_cnt;
    logic [14:0]           ref_count;
    logic                  sign_q;
    logic [15:0]           result;

    wire [3:0]  pre_mod = ctrl.osc_crystal ? dsas_pkg::PRESCALE_XTAL
                                           : dsas_pkg::PRESCALE_RC;
    wire        tick    = pre == pre_mod - 4'h1;
    wire [15:0] last_sys = 16'(SYS_TICKS - 1);
    wire [15:0] last_sig = 16'(SIG_TICKS - 1);
    wire [15:0] last_ref = 16'(REF_TICKS - 1);
    wire [15:0] last_int = 16'(dsas_pkg::INT_TICKS - 1);
    wire [15:0] phase_last = (phase == dsas_pkg::PH_SYS_ZERO) ? last_sys :
                             (phase == dsas_pkg::PH_SIG_INT)  ? last_sig :
                             (phase == dsas_pkg::PH_REF_INT)  ? last_ref : last_int;
    wire        at_last    = phase_cnt == phase_last;
    wire        phase_done = tick && at_last;
    wire        in_ref     = phase == dsas_pkg::PH_REF_INT;
    // system zero holds at its end until run/hold asks for a conversion
    wire        go_sig     = phase == dsas_pkg::PH_SYS_ZERO && phase_done && ctrl.run_hold;
    // run/hold only counts once the result is latched
    wire        early_end  = in_ref && !result_valid_flag && !ctrl.run_hold;
    wire        crossing   = in_ref && result_valid_flag && comp_zero;
    wire        ref_timeout = in_ref && result_valid_flag && phase_done;
    wire        load       = crossing || ref_timeout;
    wire        advance    = go_sig || early_end
                             || (phase != dsas_pkg::PH_SYS_ZERO && phase_done);

    always_comb
    begin
        next_phase = phase;
        if (advance)
        begin
            unique case (phase)
                dsas_pkg::PH_SYS_ZERO: next_phase = dsas_pkg::PH_SIG_INT;
                dsas_pkg::PH_SIG_INT:  next_phase = dsas_pkg::PH_REF_INT;
                dsas_pkg::PH_REF_INT:  next_phase = dsas_pkg::PH_INT_ZERO;
                dsas_pkg::PH_INT_ZERO: next_phase = dsas_pkg::PH_SYS_ZERO;
            endcase
        end
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            pre       <= 4'h0;
            phase     <= dsas_pkg::PH_SYS_ZERO;
            phase_cnt <= 16'h0000;
        end
        else
        begin
            pre   <= tick ? 4'h0 : pre + 4'h1;
            phase <= next_phase;
            if (advance)
                phase_cnt <= 16'h0000;
            else if (tick && !at_last)
                phase_cnt <= phase_cnt + 16'h0001;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // magnitude counter, sign and output latches
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            ref_count         <= 15'h0000;
            sign_q            <= 1'b0;
            result            <= 16'h0000;
            result_valid_flag <= 1'b0;
        end
        else
        begin
            if (phase != dsas_pkg::PH_REF_INT)
                ref_count <= 15'h0000;
            else if (result_valid_flag && tick && !load)
                ref_count <= ref_count + 15'h0001;
            // polarity is taken at the end of integration, so it is valid near zero
            if (phase == dsas_pkg::PH_SIG_INT && phase_done)
                sign_q <= comp_polarity;
            if (load)
                result <= {sign_q, ref_count};
            if (go_sig)
                result_valid_flag <= 1'b1;
            else if (load)
                result_valid_flag <= 1'b0;
        end
    end

    // the switch decode follows the phase register directly
    assign switches.buf_to_common = phase == dsas_pkg::PH_SYS_ZERO;
    assign switches.loop_closed   = phase == dsas_pkg::PH_SYS_ZERO;
    assign switches.input_to_int  = phase == dsas_pkg::PH_SIG_INT;
    assign switches.ref_to_int    = in_ref;
    assign switches.comp_to_buf   = phase == dsas_pkg::PH_INT_ZERO;

    assign data_o    = result;
    assign data_oe   = ctrl.data_oe;
    assign strobe_oe = {3{ctrl.strobe_mode}};

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            strobe_o <= 3'h0;
        else
            strobe_o <= {early_end || (in_ref && phase_done), go_sig, load};
    end

    ////////////////////////////////////////////////////////////////////////
    // register readback
    wire [31:0] status_word = {25'h0000000, strobe_i, result_valid_flag, sign_q, phase};
    wire [31:0] rd_word = (s_axi_araddr == dsas_pkg::ADDR_CTRL)   ? {28'h0000000, ctrl} :
                          (s_axi_araddr == dsas_pkg::ADDR_STATUS) ? status_word :
                          (s_axi_araddr == dsas_pkg::ADDR_RESULT) ? {16'h0000, result} :
                          32'h00000000;
    wire        rd_mapped = s_axi_araddr == dsas_pkg::ADDR_CTRL
                            || s_axi_araddr == dsas_pkg::ADDR_STATUS
                            || s_axi_araddr == dsas_pkg::ADDR_RESULT;

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h00000000;
            s_axi_rresp  <= dsas_pkg::RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_word;
            s_axi_rresp  <= rd_mapped ? dsas_pkg::RESP_OKAY : dsas_pkg::RESP_SLVERR;
        end
        else if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);

    a_xtal_tick_gap: assert property ((tick && ctrl.osc_crystal && $past(ctrl.osc_crystal))
        |=> (!tick || !ctrl.osc_crystal) [*8]) else $error("crystal tick came too soon");
    a_rc_tick_each: assert property ((!ctrl.osc_crystal && $past(!ctrl.osc_crystal)
        && $past(tick)) |-> tick) else $error("rc mode must tick every cycle");
    a_phase_order: assert property (phase != $past(phase) |->
        phase == dsas_pkg::dsas_phase_t'($past(phase) + 2'h1))
        else $error("phase skipped");
    a_hold_sys_zero: assert property ((phase == dsas_pkg::PH_SYS_ZERO && !ctrl.run_hold)
        |=> phase == dsas_pkg::PH_SYS_ZERO) else $error("left system zero on hold");
    a_sig_length: assert property (($past(phase) == dsas_pkg::PH_SIG_INT
        && phase != dsas_pkg::PH_SIG_INT) |-> $past(phase_cnt) == last_sig)
        else $error("signal integrate length wrong");
    a_int_length: assert property (($past(phase) == dsas_pkg::PH_INT_ZERO
        && phase != dsas_pkg::PH_INT_ZERO) |-> $past(phase_cnt) == last_int)
        else $error("integrator zero length wrong");
    a_load_result: assert property (crossing |=> !result_valid_flag
        && result == {$past(sign_q), $past(ref_count)}) else $error("bad transfer");
    a_latch_holds: assert property (!load |=> result == $past(result))
        else $error("latch changed without transfer");
    a_early_exit: assert property (early_end |=> phase == dsas_pkg::PH_INT_ZERO)
        else $error("hold did not end deintegrate");
    a_flag_ignores: assert property ((in_ref && result_valid_flag && !comp_zero
        && !phase_done) |=> phase == dsas_pkg::PH_REF_INT)
        else $error("run/hold acted while flag high");

endmodule

// *** testbench/dsas_frontend_model.sv ***
`timescale 1ns/100ps
// analog front end stand-in: the comparator trips a set number of clock cycles into deintegrate
module dsas_frontend_model (
    // clock and reset
    input  wire logic                   sys_clk,
    input  wire logic                   rst,
    // switch controls and scenario knobs
    input  wire dsas_pkg::dsas_switch_t switches,
    input  wire logic [15:0]            cross_after,
    input  wire logic                   sign_in,
    // comparator
    output logic                        comp_zero,
    output logic                        comp_polarity
);
    logic [15:0] ref_cnt;

    // polarity toggles outside signal integrate so a mistimed sample shows
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            ref_cnt       <= 16'h0000;
            comp_zero     <= 1'b0;
            comp_polarity <= 1'b0;
        end
        else
        begin
            ref_cnt       <= switches.ref_to_int ? ref_cnt + 16'h0001 : 16'h0000;
            comp_zero     <= switches.ref_to_int && (ref_cnt >= cross_after);
            comp_polarity <= switches.input_to_int ? sign_in : ~comp_polarity;
        end
    end
endmodule

// *** testbench/dsas_sequencer_test.sv ***
`timescale 1ns/100ps
module dsas_sequencer_test;
    localparam int SIG = 16;
    localparam int REF = 20;
    localparam int SYS = 8;
    logic                   sys_clk = 1'b0;
    logic                   rst = 1'b1;
    logic [7:0]             s_axi_awaddr = 8'h00;
    logic [7:0]             s_axi_araddr = 8'h00;
    logic [31:0]            s_axi_wdata = 32'h00000000;
    logic [3:0]             s_axi_wstrb = 4'hF;
    logic                   s_axi_awvalid = 1'b0;
    logic                   s_axi_wvalid = 1'b0;
    logic                   s_axi_bready = 1'b0;
    logic                   s_axi_arvalid = 1'b0;
    logic                   s_axi_rready = 1'b0;
    logic [2:0]             strobe_i = 3'h0;
    logic                   s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]             s_axi_bresp, s_axi_rresp, rsp;
    logic [31:0]            s_axi_rdata, rd;
    logic                   comp_zero, comp_polarity, data_oe, result_valid_flag;
    dsas_pkg::dsas_switch_t switches;
    logic [15:0]            data_o, prev;
    logic [15:0]            cross_after = 16'h0000;
    logic [2:0]             strobe_o, strobe_oe;
    logic                   sign_in = 1'b0;
    int                     fail_count = 0, checks = 0, cycles = 0, loads = 0, starts = 0;
    int                     seed = 12;
    int                     k;
    int                     run_cnt [3];
    int                     run_len [3];

    dsas_sequencer #(.SIG_TICKS(SIG), .REF_TICKS(REF), .SYS_TICKS(SYS)) i_dsas_sequencer (
        .sys_clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .comp_zero, .comp_polarity, .switches, .data_o,
        .data_oe, .strobe_i, .strobe_o, .strobe_oe, .result_valid_flag);
    dsas_frontend_model i_dsas_frontend_model (.sys_clk, .rst, .switches, .cross_after,
        .sign_in, .comp_zero, .comp_polarity);

    always #2 sys_clk = ~sys_clk;

    ////////////////////////////////////////////////////////////////////////
    // phase lengths from the switch bits, strobe counts, hang guard
    always @(posedge sys_clk)
    begin
        cycles <= cycles + 1;
        loads  <= loads + int'(strobe_o[0]);
        starts <= starts + int'(strobe_o[1]);
        for (int i = 0; i < 3; i++)
        begin
            run_cnt[i] <= switches[i] ? run_cnt[i] + 1 : 0;
            if (!switches[i] && run_cnt[i] != 0) run_len[i] <= run_cnt[i];
        end
        if (cycles == 30000)
        begin
            fail_count++;
            stop_test();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("BAD at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // readies and answers are sampled at the rising edge that they qualify
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic b_ok;
        b_ok = 1'b0;
        r = 2'h0;
        @(posedge sys_clk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        while (!b_ok)
        begin
            @(posedge sys_clk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid)
            begin
                b_ok = 1'b1;
                r = s_axi_bresp;
            end
        end
        s_axi_bready <= 1'b0;
    endtask

    task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ok;
        ok = 1'b0;
        d = 32'h00000000;
        r = 2'h0;
        @(posedge sys_clk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        while (!ok)
        begin
            @(posedge sys_clk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid)
            begin
                ok = 1'b1;
                d = s_axi_rdata;
                r = s_axi_rresp;
            end
        end
        s_axi_rready <= 1'b0;
    endtask

    task automatic wait_flag(input logic lvl);
        int n;
        n = 0;
        while (result_valid_flag !== lvl && n < 9000)
        begin
            @(negedge sys_clk);
            n++;
        end
        check(result_valid_flag, lvl);
    endtask

    task automatic stop_test();
        $display("checks %0d, mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (12) @(posedge sys_clk);
        rst <= 1'b0;
        check(switches, 5'h18);
        axi_read(dsas_pkg::ADDR_CTRL, rd, rsp);
        check(rd, 32'h1);
        strobe_i <= 3'($random(seed));
        axi_read(dsas_pkg::ADDR_STATUS, rd, rsp);
        check({rd[6:3], rd[1:0]}, {strobe_i, 3'h0});
        axi_read(8'h0C, rd, rsp);
        check({rsp, rd}, {dsas_pkg::RESP_SLVERR, 32'h0});
        axi_write(8'h10, 32'h0, rsp);
        check(rsp, dsas_pkg::RESP_SLVERR);
        axi_write(dsas_pkg::ADDR_CTRL, 32'hC, rsp);
        check({rsp, data_oe, strobe_oe}, {dsas_pkg::RESP_OKAY, 4'hF});
        repeat (50) @(posedge sys_clk);
        check({switches, result_valid_flag}, {5'h18, 1'b0});
        $display("register and hold test done");
        // continuous run in fast oscillator mode, random crossing and sign
        k = {$random(seed)} % 8;
        cross_after <= 16'(k);
        sign_in <= 1'($random(seed));
        axi_write(dsas_pkg::ADDR_CTRL, 32'h6, rsp);
        wait_flag(1'b1);
        wait_flag(1'b0);
        check(data_o[15], sign_in);
        check(int'(data_o[14:0]) >= k && int'(data_o[14:0]) <= k + 2, 1'b1);
        axi_read(dsas_pkg::ADDR_RESULT, rd, rsp);
        check(rd, {16'h0, data_o});
        prev = data_o;
        cross_after <= 16'hFFFF;
        sign_in <= ~sign_in;
        wait_flag(1'b1);
        check(run_len[2], SIG);
        check(run_len[1], REF);
        check(run_len[0], 4096);
        check(data_o, prev);
        wait_flag(1'b0);
        check(int'(data_o[14:0]) >= REF - 3 && int'(data_o[14:0]) <= REF, 1'b1);
        check(data_o[15], sign_in);
        $display("continuous conversion test done");
        // run/hold dropped mid-conversion, then cut deintegrate short
        cross_after <= 16'h0002;
        wait_flag(1'b1);
        axi_write(dsas_pkg::ADDR_CTRL, 32'h4, rsp);
        wait_flag(1'b0);
        repeat (4) @(posedge sys_clk);
        check(switches.comp_to_buf, 1'b1);
        repeat (4200) @(posedge sys_clk);
        check(run_len[1] < REF, 1'b1);
        check({switches, result_valid_flag, data_oe}, {5'h18, 2'b01});
        check({starts, loads}, {32'd3, 32'd3});
        $display("on-command conversion test done");
        stop_test();
    end
endmodule
